/* File: bench/contact_bank.sv */
// contacts of a controller driving the seven input terminals
`timescale 1ns/1ps
module contact_bank (
  input  wire logic       aclk,
  input  wire logic [6:0] want,
  input  wire logic       slow,
  output logic      [6:0] pins
);
  logic [6:0] d1_r, d2_r, d3_r;
  // relays close after one cycle, slow ones after three
  always_ff @(posedge aclk) begin
    d1_r <= want;
    d2_r <= d1_r;
    d3_r <= d2_r;
  end
  assign pins = slow ? d3_r : d1_r;
endmodule // contact_bank

/* File: bench/ifa_props.sv */
// checker of handshake timing and output behaviour of the input router
`timescale 1ns/1ps
module ifa_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        alarm_clear_pulse,
  input wire logic        panel_lock_release,
  input wire logic        torque_limit_disable
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // responses stand until taken, block new requests meanwhile, and come on time
  a_b_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  // a held alarm level must not repeat the clear
  a_clear_single_pulse: assert property (alarm_clear_pulse |=> !alarm_clear_pulse)
    else $error("alarm clear wider than one cycle");
  a_unassigned_active: assert property ($rose(aresetn) |-> ##2 panel_lock_release && torque_limit_disable)
    else $error("unassigned inputs not held active");

  c_write_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
  c_alarm_clear: cover property (alarm_clear_pulse);
endmodule // ifa_props

bind input_function_assignment ifa_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .alarm_clear_pulse,
  .panel_lock_release, .torque_limit_disable);

/* File: bench/tb_top.sv */
// self-checking bench of the input function router
`timescale 1ns/1ps
module tb_top;
  import input_assign_pkg::*;
  logic        aclk, aresetn, slow;
  logic [6:0]  want, term;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, op_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        run_forward_cmd, run_reverse_cmd, stop_mode_sel, brake_release_cmd, external_fault_stop;
  logic        thermal_stop_input, alarm_clear_pulse, panel_lock_release, torque_limit_disable;
  logic [15:0] general_bits;
  logic [28:0] fv;
  int          fails, comparisons, cyc, pulses;
  // outputs packed in function order for whole-vector compares
  assign fv = {general_bits, op_select, torque_limit_disable, panel_lock_release, alarm_clear_pulse,
               thermal_stop_input, external_fault_stop, brake_release_cmd, stop_mode_sel,
               run_reverse_cmd, run_forward_cmd};
  contact_bank u_bank (.aclk, .want, .slow, .pins(term));
  input_function_assignment u_dut (.aclk, .aresetn, .input_terminal(term), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .run_forward_cmd, .run_reverse_cmd, .stop_mode_sel, .brake_release_cmd,
    .external_fault_stop, .thermal_stop_input, .alarm_clear_pulse, .panel_lock_release,
    .torque_limit_disable, .op_select, .general_bits);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // cycle ceiling cuts a hang short; pulses counted for the clear check
  always @(posedge aclk) begin
    cyc++;
    if (alarm_clear_pulse === 1'b1) pulses++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // ready raised late so the response has to stand a cycle
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    // ready raised late so the read data has to stand a cycle
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // pin change needs relay, two sync stages and the output register
  task automatic pins(input logic [6:0] w);
    want <= w;
    repeat (8) @(posedge aclk);
  endtask
  task automatic t_reset();
    logic [7:0] dflt [7] = '{8'h01, 8'h02, 8'h13, 8'h30, 8'h18, 8'h14, 8'h16};
    for (int i = 0; i < 7; i++) rd(8'(i * 4), {24'h0, dflt[i]}, 2'h0);
    rd(8'h1C, 32'h0, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h28, 32'h1, 2'h2);
    pins(7'h40);
    chk({3'h0, fv}, 32'h180);
  endtask
  task automatic t_codes();
    logic [7:0] cd [15] = '{8'h00, 8'h01, 8'h02, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1B, 8'h20, 8'h28, 8'h2F,
                            8'h30, 8'h33, 8'h36, 8'h63};
    int         ix [15] = '{-1, 0, 1, 2, 3, 4, 5, 7, 13, 21, 28, 9, 12, 8, -1};
    logic [28:0] e;
    // terminal 0 stepped through the codes one at a time, thermal pin held on
    for (int k = 0; k < 15; k++) begin
      wr(8'h00, {24'h0, cd[k]}, 2'h0);
      for (int l = 0; l < 2; l++) begin
        pins({6'h20, l[0]});
        e = 29'h180;
        if (ix[k] >= 0) e[ix[k]] = l[0] ^ (cd[k] == 8'h15 || cd[k] == 8'h16);
        chk({3'h0, fv}, {3'h0, e});
      end
    end
    wr(8'h00, 32'h1, 2'h0);
  endtask
  task automatic t_merge();
    wr(8'h04, 32'h1, 2'h0);
    pins(7'h42);
    chk({31'h0, run_forward_cmd}, 32'h1);
    wr(8'h04, 32'h2, 2'h0);
    wr(8'h1C, 32'h1, 2'h0);
    pins(7'h40);
    chk({31'h0, run_forward_cmd}, 32'h1);
    wr(8'h1C, 32'h0, 2'h0);
    wr(8'h00, 32'h1B, 2'h0);
    wr(8'h04, 32'h1B, 2'h0);
    pins(7'h41);
    chk({31'h0, panel_lock_release}, 32'h0);
    pins(7'h43);
    chk({31'h0, panel_lock_release}, 32'h1);
    wr(8'h20, 32'h1, 2'h0);
    wr(8'h24, 32'h81, 2'h0);
    pins(7'h43);
    chk({31'h0, panel_lock_release}, 32'h0);
    chk({31'h0, run_forward_cmd}, 32'h1);
    wr(8'h24, 32'h0, 2'h0);
    wr(8'h00, 32'h1, 2'h0);
    wr(8'h04, 32'h2, 2'h0);
  endtask
  // slow contacts on the clear terminal; only the release may clear
  task automatic t_alarm();
    slow <= 1'b1;
    pins(7'h40);
    pulses = 0;
    pins(7'h50);
    repeat (8) @(posedge aclk);
    chk(32'(pulses), 32'h0);
    pins(7'h40);
    repeat (8) @(posedge aclk);
    chk(32'(pulses), 32'h1);
    slow <= 1'b0;
  endtask
  initial begin
    aresetn = 1'b0;
    slow = 1'b0;
    want = 7'h40;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_codes();
    t_merge();
    t_alarm();
    print_verdict();
  end
endmodule // tb_top

/* File: core/input_function_assignment.sv */
// input terminal to function router with AXI4-Lite configuration registers
// Function
// - per-terminal function select, code 0 unused
// - reset defaults 1,2,19,48,24,20,22
// - code 1 drives forward run
// - code 2 drives reverse run
// - code 19 drives stop-style selector
// - code 20 drives brake release
// - codes 21,22 normally closed stop inputs
// - code 24 drives alarm clear
// - alarm clear acts on falling edge
// - code 27 normally closed panel lock release
// - codes 32-47 general bits 0-15
// - codes 48-51 operation select bits 0-3
// - code 54 normally closed torque limit disable
// - duplicate assignments combine by OR, except panel/torque inputs
// - unassigned panel/torque inputs held active
// - multi-source panel/torque inputs combine by AND
// - terminals and network both drive functions
// - per-terminal polarity, 1 inverts
`timescale 1ns/1ps
module input_function_assignment
  import input_assign_pkg::*;
(
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic [input_assign_pkg::TERM_COUNT-1:0] input_terminal,
  input  wire logic [7:0]                            s_axi_awaddr,
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  input  wire logic [7:0]                            s_axi_araddr,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  output logic                                       run_forward_cmd,
  output logic                                       run_reverse_cmd,
  output logic                                       stop_mode_sel,
  output logic                                       brake_release_cmd,
  output logic                                       external_fault_stop,
  output logic                                       thermal_stop_input,
  output logic                                       alarm_clear_pulse,
  output logic                                       panel_lock_release,
  output logic                                       torque_limit_disable,
  output logic [input_assign_pkg::SEL_COUNT-1:0]     op_select,
  output logic [input_assign_pkg::GP_COUNT-1:0]      general_bits
);
  import input_assign_pkg::*;

  // code to one-hot function vector; anything not listed maps to nothing
  function automatic fvec_t code_to_func(input code_t code);
    fvec_t v;
    v = '0;
    if (code == CODE_FWD)      v[FN_FWD]   = 1'b1;
    if (code == CODE_REV)      v[FN_REV]   = 1'b1;
    if (code == CODE_STOPMODE) v[FN_STOP]  = 1'b1;
    if (code == CODE_BRAKE)    v[FN_BRAKE] = 1'b1;
    if (code == CODE_EXTSTOP)  v[FN_EXT]   = 1'b1;
    if (code == CODE_THERMAL)  v[FN_TH]    = 1'b1;
    if (code == CODE_ALMCLR)   v[FN_ALM]   = 1'b1;
    if (code == CODE_PANEL)    v[FN_PANEL] = 1'b1;
    if (code == CODE_TLDIS)    v[FN_TLDIS] = 1'b1;
    if (code >= CODE_GP_FIRST && code <= CODE_GP_LAST)
      v[FN_GP0 + 32'(code - CODE_GP_FIRST)] = 1'b1;
    if (code >= CODE_OP_FIRST && code <= CODE_OP_LAST)
      v[FN_OP0 + 32'(code - CODE_OP_FIRST)] = 1'b1;
    return v; // code 0 and gaps give an empty vector
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  code_t                 func_sel_r [TERM_COUNT];
  logic [TERM_COUNT-1:0] polarity_r;
  fvec_t                 net_cmd_r;
  fvec_t                 net_en_r;
  logic [TERM_COUNT-1:0] sync1_r;
  logic [TERM_COUNT-1:0] sync2_r;
  logic [TERM_COUNT-1:0] term_on;
  fvec_t                 sel_vec [TERM_COUNT];
  fvec_t                 any_on;
  fvec_t                 any_off;
  fvec_t                 assigned;
  fvec_t                 func_state_r;
  logic                  alarm_level_r;
  logic                  aw_got_r;
  logic                  w_got_r;
  logic [7:0]            awaddr_r;
  logic [31:0]           wdata_r;
  logic [3:0]            wstrb_r;
  logic                  do_write;
  logic [31:0]           rd_word;
  logic                  rd_hit;
  logic                  wr_hit;

  // two-stage synchroniser on the raw pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= input_terminal;
      sync2_r <= sync1_r;
    end
  end

  // per terminal: contact sense and decoded function
  genvar t;
  generate
    for (t = 0; t < TERM_COUNT; t++) begin : g_term
      assign term_on[t] = sync2_r[t] ^ polarity_r[t];
      assign sel_vec[t] = code_to_func(func_sel_r[t]);
    end
  endgenerate

  // gather every source per function; network counts as one more source
  always_comb begin
    any_on   = net_en_r & net_cmd_r;
    any_off  = net_en_r & ~net_cmd_r;
    assigned = net_en_r;
    for (int i = 0; i < TERM_COUNT; i++) begin
      any_on   = any_on | (sel_vec[i] & {FN_COUNT{term_on[i]}});
      any_off  = any_off | (sel_vec[i] & {FN_COUNT{~term_on[i]}});
      assigned = assigned | sel_vec[i];
    end
  end

  // resolved function levels, refreshed every cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_state_r <= '0;
    end else begin
      func_state_r           <= any_on;
      // stop inputs: any opened contact requests the stop
      func_state_r[FN_EXT]   <= any_off[FN_EXT];
      func_state_r[FN_TH]    <= any_off[FN_TH];
      // all sources must be on; no source at all means held on
      func_state_r[FN_PANEL] <= ~assigned[FN_PANEL] | ~any_off[FN_PANEL];
      func_state_r[FN_TLDIS] <= ~assigned[FN_TLDIS] | ~any_off[FN_TLDIS];
    end
  end

  // alarm clear fires when the resolved level goes from on to off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_level_r     <= 1'b0;
      alarm_clear_pulse <= 1'b0;
    end else begin
      alarm_level_r     <= func_state_r[FN_ALM];
      alarm_clear_pulse <= alarm_level_r & ~func_state_r[FN_ALM];
    end
  end

  // function outputs straight from the resolved register
  assign run_forward_cmd      = func_state_r[FN_FWD];
  assign run_reverse_cmd      = func_state_r[FN_REV];
  assign stop_mode_sel        = func_state_r[FN_STOP];
  assign brake_release_cmd    = func_state_r[FN_BRAKE];
  assign external_fault_stop  = func_state_r[FN_EXT];
  assign thermal_stop_input   = func_state_r[FN_TH];
  assign panel_lock_release   = func_state_r[FN_PANEL];
  assign torque_limit_disable = func_state_r[FN_TLDIS];
  assign op_select            = func_state_r[FN_OP0 +: SEL_COUNT];
  assign general_bits         = func_state_r[FN_GP0 +: GP_COUNT];

  // write channel capture: address and data may arrive in either order
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign do_write      = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
    end
  end

  // address map check, shared by both directions
  function automatic logic addr_ok(input logic [7:0] a, input logic writable);
    return (a[1:0] == 2'h0) && ((a <= OFS_NET_EN) || (!writable && a <= OFS_FUNC_ST));
  endfunction

  // byte address of one terminal's select word; shared by write decode and read mux
  function automatic logic [7:0] sel_addr(input int idx);
    return OFS_SEL0 + 8'(idx * OFS_STRIDE);
  endfunction

  assign wr_hit = addr_ok(awaddr_r, 1'b1);

  // function select words; status words are read-only and never written here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < TERM_COUNT; i++) begin
        func_sel_r[i] <= RST_SEL[i];
      end
    end else if (do_write && wr_hit) begin
      for (int i = 0; i < TERM_COUNT; i++) begin
        if (awaddr_r == sel_addr(i))
          func_sel_r[i] <= CODE_W'(merge({24'h0, func_sel_r[i]}, wdata_r, wstrb_r));
      end
    end
  end

  // contact sense per terminal, applied before decoding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      polarity_r <= RST_POLARITY;
    end else if (do_write && wr_hit && awaddr_r == OFS_POLARITY) begin
      polarity_r <= TERM_COUNT'(merge({25'h0, polarity_r}, wdata_r, wstrb_r));
    end
  end

  // network levels and the mask of functions the network takes part in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      net_cmd_r <= RST_NET;
      net_en_r  <= RST_NET;
    end else if (do_write && wr_hit) begin
      if (awaddr_r == OFS_NET_CMD)
        net_cmd_r <= FN_COUNT'(merge({3'h0, net_cmd_r}, wdata_r, wstrb_r));
      if (awaddr_r == OFS_NET_EN)
        net_en_r <= FN_COUNT'(merge({3'h0, net_en_r}, wdata_r, wstrb_r));
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = addr_ok(s_axi_araddr, 1'b0);
    for (int i = 0; i < TERM_COUNT; i++) begin
      if (s_axi_araddr == sel_addr(i)) rd_word = {24'h0, func_sel_r[i]};
    end
    if (s_axi_araddr == OFS_POLARITY) rd_word = {25'h0, polarity_r};
    if (s_axi_araddr == OFS_NET_CMD)  rd_word = {3'h0, net_cmd_r};
    if (s_axi_araddr == OFS_NET_EN)   rd_word = {3'h0, net_en_r};
    if (s_axi_araddr == OFS_TERM_ST)  rd_word = {25'h0, term_on};
    if (s_axi_araddr == OFS_FUNC_ST)  rd_word = {3'h0, func_state_r};
  end

  // one read at a time; rdata held until taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? rd_word : 32'h0000_0000;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // input_function_assignment

/* File: include/input_assign_pkg.sv */
// constants, codes and register map of the input function assignment block
package input_assign_pkg;
  localparam int unsigned TERM_COUNT = 7;
  localparam int unsigned CODE_W     = 8;
  localparam int unsigned FN_COUNT   = 29;
  localparam int unsigned GP_COUNT   = 16;
  localparam int unsigned SEL_COUNT  = 4;

  typedef logic [CODE_W-1:0]   code_t;
  typedef logic [FN_COUNT-1:0] fvec_t;

  // assignment numbers
  localparam code_t CODE_UNUSED   = 8'h00;
  localparam code_t CODE_FWD      = 8'h01;
  localparam code_t CODE_REV      = 8'h02;
  localparam code_t CODE_STOPMODE = 8'h13;
  localparam code_t CODE_BRAKE    = 8'h14;
  localparam code_t CODE_EXTSTOP  = 8'h15;
  localparam code_t CODE_THERMAL  = 8'h16;
  localparam code_t CODE_ALMCLR   = 8'h18;
  localparam code_t CODE_PANEL    = 8'h1B;
  localparam code_t CODE_GP_FIRST = 8'h20;
  localparam code_t CODE_GP_LAST  = 8'h2F;
  localparam code_t CODE_OP_FIRST = 8'h30;
  localparam code_t CODE_OP_LAST  = 8'h33;
  localparam code_t CODE_TLDIS    = 8'h36;

  // bit positions in the internal function vector
  localparam int unsigned FN_FWD    = 0;
  localparam int unsigned FN_REV    = 1;
  localparam int unsigned FN_STOP   = 2;
  localparam int unsigned FN_BRAKE  = 3;
  localparam int unsigned FN_EXT    = 4;
  localparam int unsigned FN_TH     = 5;
  localparam int unsigned FN_ALM    = 6;
  localparam int unsigned FN_PANEL  = 7;
  localparam int unsigned FN_TLDIS  = 8;
  localparam int unsigned FN_OP0    = 9;
  localparam int unsigned FN_GP0    = 13;

  // reset assignment per terminal
  localparam code_t RST_SEL [TERM_COUNT] = '{CODE_FWD, CODE_REV, CODE_STOPMODE, CODE_OP_FIRST,
                                             CODE_ALMCLR, CODE_BRAKE, CODE_THERMAL};
  localparam logic [TERM_COUNT-1:0] RST_POLARITY = 7'h00;
  localparam fvec_t                 RST_NET      = 29'h0000_0000;

  // register byte offsets
  localparam logic [7:0] OFS_SEL0     = 8'h00;
  localparam logic [7:0] OFS_SEL_LAST = 8'h18;
  localparam logic [7:0] OFS_STRIDE   = 8'h04;
  localparam logic [7:0] OFS_POLARITY = 8'h1C;
  localparam logic [7:0] OFS_NET_CMD  = 8'h20;
  localparam logic [7:0] OFS_NET_EN   = 8'h24;
  localparam logic [7:0] OFS_TERM_ST  = 8'h28;
  localparam logic [7:0] OFS_FUNC_ST  = 8'h2C;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
